/* File: press_fit_pkg.sv */
// Package: register map, field positions, reset values and timing for the press-fit result link
package press_fit_pkg;
  // ----------------------------------------------------------------------------
  // Register offsets (byte addresses, word aligned)
  // ----------------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] RESULT_OFS = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
  localparam logic [7:0] FILE_NAME_LO_OFS = 8'h10;
  localparam logic [7:0] FILE_NAME_HI_OFS = 8'h14;
  localparam logic [7:0] SEQ_COUNT_OFS = 8'h18;
  localparam logic [7:0] CHECK_LIMIT_OFS = 8'h1C;
  localparam logic [7:0] CHECK_VALUE_OFS = 8'h20;

  // ----------------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------------
  localparam int CTRL_AUTO_REC = 0;
  localparam int CTRL_MANUAL_START = 1;
  localparam int CTRL_REC_STOP = 2;
  localparam int CTRL_CAL_ACTIVE = 3;

  // ----------------------------------------------------------------------------
  // Event bits in status and mask registers
  // ----------------------------------------------------------------------------
  localparam int EV_DONE = 0;
  localparam int EV_FAIL = 1;
  localparam int EV_WIRING = 2;
  localparam int EV_CHECK_FAIL = 3;
  localparam int EV_PRINT = 4;
  localparam int EV_REC_ABORT = 5;
  localparam int EV_COUNT = 6;

  // ----------------------------------------------------------------------------
  // Window codes and reset values
  // ----------------------------------------------------------------------------
  localparam logic [3:0] CODE_ALL_PASS = 4'h0;
  localparam logic [3:0] CODE_THREAD_IN = 4'h1;
  localparam logic [3:0] CODE_END = 4'h8;
  localparam logic [3:0] CODE_SEVERAL = 4'hF;
  localparam int WINDOW_COUNT = 8;
  localparam int NAME_CHARS = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [11:0] LIMIT_RESET = 12'h010;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ----------------------------------------------------------------------------
  // Timing: zero balance waits the controller must allow (informative)
  // ----------------------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int ZERO_BAL_STD_MS = 250;
  localparam int ZERO_BAL_FAST_MS = 50;
  localparam int ZERO_BAL_STD_CYCLES = ZERO_BAL_STD_MS * (CLK_HZ / 1000);
  localparam int ZERO_BAL_FAST_CYCLES = ZERO_BAL_FAST_MS * (CLK_HZ / 1000);

  // Evaluation sequencer, Gray coded along idle -> measure -> verdict
  typedef enum logic [1:0] {
    EVAL_IDLE = 2'b00,
    EVAL_MEASURE = 2'b01,
    EVAL_VERDICT = 2'b11
  } eval_state_t;
endpackage : press_fit_pkg

/* File: press_fit_plc_result_link.sv */
// Press-fit result and control link between evaluation channel and PLC
//
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps

module press_fit_plc_result_link (
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Controller pins
  input wire logic startPin,
  input wire logic checkPin,
  input wire logic printPin,
  // Evaluation core side, from other clock domain / pins
  input wire logic evalDonePin,
  input wire logic [7:0] windowFailPin,
  input wire logic wiringFaultPin,
  input wire logic [11:0] forceValue,
  input wire logic [11:0] displValue,
  // Outputs to controller and host logic
  output logic passOut,
  output logic fail_verdict_out,
  output logic [3:0] windowCodeOut,
  output logic wiringOkOut_n,
  output logic busyOut,
  output logic checkFailOut,
  output logic printStartOut,
  output logic recordingOut,
  output logic irqOut
);

  // --------------------------------------------------------------------------
  // State record
  // --------------------------------------------------------------------------
  typedef struct packed {
    // Pin synchronisers, two stages plus an edge stage for start, print and done, three unused-edge stages for check; two stages for wiring and window lines
    logic [2:0] startSync;
    logic [2:0] checkSync;
    logic [2:0] printSync;
    logic [2:0] doneSync;
    logic [1:0] wiringSync;
    logic [7:0] failSync1;
    logic [7:0] failSync2;
    // Evaluation result, held for the controller
    press_fit_pkg::eval_state_t eval;
    logic pass;
    logic fail;
    logic [3:0] code;
    logic wiringOk;
    logic checkFail;
    logic printStart;
    logic recording;
    // Recording, check and interrupt settings
    logic autoRec;
    logic calActive;
    logic [63:0] fileName;
    logic [11:0] seqCount;
    logic [11:0] forceSet;
    logic [11:0] displSet;
    logic [11:0] limit;
    logic [press_fit_pkg::EV_COUNT-1:0] status;
    logic [press_fit_pkg::EV_COUNT-1:0] mask;
    // Bus response and interrupt, all registered
    logic [31:0] rdata;
    logic ack;
    logic waitReq;
    logic busy;
    logic irq;
  } state_t;

  state_t state_reg;
  state_t state_next;
  // Combinational helpers; four bits count up to eight failing windows
  logic [3:0] failCount;
  logic [3:0] failIndex;
  logic [press_fit_pkg::EV_COUNT-1:0] events;
  // Edge and level views of the synchronised pins
  logic startRise;
  logic checkLevel;
  logic printRise;
  logic doneRise;
  // Bus decode
  logic access;
  logic [31:0] wmask;
  logic [11:0] forceDiff;
  logic [11:0] displDiff;

  // --------------------------------------------------------------------------
  // Window encoder: count failures and find the lowest failing number
  // --------------------------------------------------------------------------
  // Scanning downward leaves the lowest failing window in failIndex; it is
  // used only when exactly one window failed
  always_comb begin
    failCount = 4'h0;
    failIndex = press_fit_pkg::CODE_ALL_PASS;
    for (int i = press_fit_pkg::WINDOW_COUNT - 1; i >= 0; i--) begin
      if (state_reg.failSync2[i]) begin
        failCount = failCount + 4'h1;
        failIndex = 4'(i + 1);
      end
    end
  end

  // Absolute differences against set values for the transducer check
  // Unsigned magnitudes, so a value below its set point cannot wrap to a pass
  assign forceDiff = (forceValue >= state_reg.forceSet) ? forceValue - state_reg.forceSet
                                                         : state_reg.forceSet - forceValue;
  assign displDiff = (displValue >= state_reg.displSet) ? displValue - state_reg.displSet
                                                         : state_reg.displSet - displValue;

  // Edges are taken only from the second and third stage, never the first
  // The first stage may still be settling, so it feeds nothing but the next stage
  assign startRise = state_reg.startSync[1] & ~state_reg.startSync[2];
  assign printRise = state_reg.printSync[1] & ~state_reg.printSync[2];
  assign doneRise = state_reg.doneSync[1] & ~state_reg.doneSync[2];
  assign checkLevel = state_reg.checkSync[1];
  // A held request is not taken again in the cycle of its own acknowledge
  assign access = (read | write) & ~state_reg.ack;

  // Byte enables widened to a bit mask, one generate lane per byte
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[b*8 +: 8] = {8{byteenable[b]}};
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    events = '0;
    // Two flip-flops ahead of any logic for every pin input except forceValue and displValue
    state_next.startSync = {state_reg.startSync[1:0], startPin};
    state_next.checkSync = {state_reg.checkSync[1:0], checkPin};
    state_next.printSync = {state_reg.printSync[1:0], printPin};
    state_next.doneSync = {state_reg.doneSync[1:0], evalDonePin};
    state_next.wiringSync = {state_reg.wiringSync[0], wiringFaultPin};
    // The window lines are taken as a word; the core holds them before done rises
    state_next.failSync1 = windowFailPin;
    state_next.failSync2 = state_reg.failSync1;
    state_next.printStart = 1'b0;
    state_next.ack = 1'b0;

    // Evaluation sequencer
    // A start rise while measuring and a done rise outside it are both ignored
    unique case (state_reg.eval)
      press_fit_pkg::EVAL_IDLE,
      press_fit_pkg::EVAL_VERDICT: begin
        if (startRise) begin
          // Verdict and code stay put until here so the PLC can sample them
          state_next.eval = press_fit_pkg::EVAL_MEASURE;
          state_next.pass = 1'b0;
          state_next.fail = 1'b0;
          // Code is cleared with the verdict so a stale number is never shown
          state_next.code = press_fit_pkg::CODE_ALL_PASS;
          if (state_reg.autoRec) begin
            state_next.recording = 1'b1;
          end
        end
      end
      press_fit_pkg::EVAL_MEASURE: begin
        if (doneRise) begin
          // Driving pass or fail closes the evaluation
          state_next.eval = press_fit_pkg::EVAL_VERDICT;
          events[press_fit_pkg::EV_DONE] = 1'b1;
          if (failCount == 4'h0) begin
            state_next.pass = 1'b1;
            state_next.code = press_fit_pkg::CODE_ALL_PASS;
          end else begin
            state_next.fail = 1'b1;
            events[press_fit_pkg::EV_FAIL] = 1'b1;
            // A single failure gives its number, several give all ones
            state_next.code = (failCount == 4'h1) ? failIndex
                                                  : press_fit_pkg::CODE_SEVERAL;
          end
        end
      end
      default: begin
        state_next.eval = press_fit_pkg::EVAL_IDLE;
      end
    endcase

    // Wiring fault output, also pulled low during calibration
    state_next.wiringOk = ~state_reg.wiringSync[1] & ~state_reg.calActive;
    // Level-set event: clearing it while the fault persists does not stick
    if (state_reg.wiringSync[1]) begin
      events[press_fit_pkg::EV_WIRING] = 1'b1;
    end

    // Transducer check runs only while the check input is held
    // A stale result is dropped together with the request
    if (checkLevel) begin
      state_next.checkFail = (forceDiff > state_reg.limit) | (displDiff > state_reg.limit);
      events[press_fit_pkg::EV_CHECK_FAIL] = state_next.checkFail;
    end else begin
      state_next.checkFail = 1'b0;
    end

    // Print task launched on the rising edge of the print pulse
    // The pulse may last many cycles; only its leading edge counts
    if (printRise) begin
      state_next.printStart = 1'b1;
      events[press_fit_pkg::EV_PRINT] = 1'b1;
    end

    // Register access, one wait state then acknowledge
    // Read data is registered, which costs the one wait state of every access
    if (access) begin
      state_next.ack = 1'b1;
      state_next.rdata = press_fit_pkg::UNMAPPED_READ;
      if (read) begin
        unique case (address)
          press_fit_pkg::CTRL_OFS: begin
            state_next.rdata = {28'h0, state_reg.calActive, 1'b0, state_reg.recording,
                                state_reg.autoRec};
          end
          press_fit_pkg::RESULT_OFS: begin
            state_next.rdata = {24'h0, state_reg.checkFail, state_reg.eval == 
                                press_fit_pkg::EVAL_MEASURE, state_reg.fail, state_reg.pass,
                                state_reg.code};
          end
          press_fit_pkg::IRQ_STATUS_OFS: state_next.rdata = {26'h0, state_reg.status};
          press_fit_pkg::IRQ_MASK_OFS: state_next.rdata = {26'h0, state_reg.mask};
          press_fit_pkg::FILE_NAME_LO_OFS: state_next.rdata = state_reg.fileName[31:0];
          press_fit_pkg::FILE_NAME_HI_OFS: state_next.rdata = state_reg.fileName[63:32];
          press_fit_pkg::SEQ_COUNT_OFS: state_next.rdata = {20'h0, state_reg.seqCount};
          press_fit_pkg::CHECK_LIMIT_OFS: state_next.rdata = {20'h0, state_reg.limit};
          press_fit_pkg::CHECK_VALUE_OFS: begin
            state_next.rdata = {4'h0, state_reg.displSet, 4'h0, state_reg.forceSet};
          end
          default: state_next.rdata = press_fit_pkg::UNMAPPED_READ;
        endcase
      end else begin
        unique case (address)
          press_fit_pkg::CTRL_OFS: begin
            if (byteenable[0]) begin
              state_next.autoRec = writedata[press_fit_pkg::CTRL_AUTO_REC];
              state_next.calActive = writedata[press_fit_pkg::CTRL_CAL_ACTIVE];
              if (writedata[press_fit_pkg::CTRL_MANUAL_START]) begin
                state_next.recording = 1'b1;
              end
              // A stop counts only while a file is open, so a stray stop keeps the count
              if (writedata[press_fit_pkg::CTRL_REC_STOP] && state_reg.recording) begin
                // Interrupted file: bump the suffix counter
                state_next.recording = 1'b0;
                state_next.seqCount = state_reg.seqCount + 12'h001;
                events[press_fit_pkg::EV_REC_ABORT] = 1'b1;
              end
            end
          end
          press_fit_pkg::IRQ_MASK_OFS: begin
            if (byteenable[0]) begin
              // Bits above the event count are dropped
              state_next.mask = writedata[press_fit_pkg::EV_COUNT-1:0];
            end
          end
          // Eight characters, one byte each, in two words
          // Lane writes let software patch a single character
          press_fit_pkg::FILE_NAME_LO_OFS: begin
            state_next.fileName[31:0] = (state_reg.fileName[31:0] & ~wmask)
                                        | (writedata & wmask);
          end
          press_fit_pkg::FILE_NAME_HI_OFS: begin
            state_next.fileName[63:32] = (state_reg.fileName[63:32] & ~wmask)
                                         | (writedata & wmask);
          end
          press_fit_pkg::CHECK_LIMIT_OFS: begin
            // The 12-bit limit spans both low lanes
            if (&byteenable[1:0]) begin
              state_next.limit = writedata[11:0];
            end
          end
          press_fit_pkg::CHECK_VALUE_OFS: begin
            // Both set values change together, never half a pair
            if (&byteenable) begin
              state_next.forceSet = writedata[11:0];
              state_next.displSet = writedata[27:16];
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Sticky status: write one clears, but a fresh event wins
    if (access && write && address == press_fit_pkg::IRQ_STATUS_OFS && byteenable[0]) begin
      state_next.status = state_reg.status & ~writedata[press_fit_pkg::EV_COUNT-1:0];
    end
    state_next.status = state_next.status | events;
    state_next.irq = |(state_next.status & state_next.mask);
    // Busy and waitrequest get flops of their own, so no output is decoded
    state_next.busy = (state_next.eval == press_fit_pkg::EVAL_MEASURE);
    state_next.waitReq = ~state_next.ack;
  end

  // --------------------------------------------------------------------------
  // State register, synchronous active-low reset
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    // Only constants in the reset branch
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.eval <= press_fit_pkg::EVAL_IDLE;
      state_reg.limit <= press_fit_pkg::LIMIT_RESET;
      state_reg.wiringOk <= 1'b1;
      state_reg.waitReq <= 1'b1; // Bus rests with waitrequest high
    end else begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs straight from flip-flops
  // Nothing is decoded here, so no output can glitch toward the controller
  // --------------------------------------------------------------------------
  assign readdata = state_reg.rdata;
  assign waitrequest = state_reg.waitReq;
  assign passOut = state_reg.pass;
  assign fail_verdict_out = state_reg.fail;
  assign windowCodeOut = state_reg.code;
  assign wiringOkOut_n = state_reg.wiringOk;
  assign busyOut = state_reg.busy;
  assign checkFailOut = state_reg.checkFail;
  assign printStartOut = state_reg.printStart;
  assign recordingOut = state_reg.recording;
  assign irqOut = state_reg.irq;

endmodule : press_fit_plc_result_link

/* File: press_fit_link_sva.sv */
// Checker: port-level properties of the press-fit result link
`timescale 1ns/1ps
module press_fit_link_sva (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic startPin,
  input wire logic checkPin,
  input wire logic evalDonePin,
  input wire logic wiringFaultPin,
  input wire logic passOut,
  input wire logic fail_verdict_out,
  input wire logic [3:0] windowCodeOut,
  input wire logic wiringOkOut_n,
  input wire logic busyOut,
  input wire logic checkFailOut,
  input wire logic printStartOut
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Steps of an evaluation
  // ----------------------------------------
  sequence doneSeen;
    $rose(evalDonePin) && busyOut;
  endsequence
  sequence verdictUp;
    passOut || fail_verdict_out;
  endsequence
  sequence startSeen;
    $rose(startPin) && !busyOut;
  endsequence
  // A fresh start drops a held pass and opens a measurement
  chk_start_clears: assert property (startSeen |-> ##[2:4] (busyOut && !passOut))
    else $error("start did not open a measurement");
  // Every access gets exactly one wait state, then the bus idles high again
  chk_bus_one_wait: assert property ($rose(read || write) |-> ##1 !waitrequest ##1 waitrequest)
    else $error("access not acknowledged after one wait state");
  chk_verdict_excl: assert property (!(passOut && fail_verdict_out))
    else $error("pass and fail both high");
  chk_pass_code: assert property (passOut |-> windowCodeOut == 4'h0)
    else $error("window code not zero on pass");
  chk_fail_code: assert property (fail_verdict_out |-> windowCodeOut != 4'h0)
    else $error("window code zero on fail");
  chk_code_hold: assert property (verdictUp ##1 verdictUp |-> $stable(windowCodeOut))
    else $error("window code moved while verdict stands");
  chk_done_verdict: assert property (doneSeen |-> ##[2:8] verdictUp)
    else $error("no verdict after evaluation done");
  chk_wiring_flag: assert property (wiringFaultPin [*6] |-> !wiringOkOut_n)
    else $error("wiring fault not flagged");
  chk_check_idle: assert property (!checkPin [*6] |-> !checkFailOut)
    else $error("check failure without check request");
  chk_print_pulse: assert property (printStartOut |=> !printStartOut)
    else $error("print start longer than one cycle");
endmodule : press_fit_link_sva

bind press_fit_plc_result_link press_fit_link_sva u_sva (.ref_clk, .rst_n, .read, .write,
  .waitrequest, .checkPin, .evalDonePin, .wiringFaultPin, .passOut, .fail_verdict_out,
  .windowCodeOut, .wiringOkOut_n, .busyOut, .checkFailOut, .printStartOut, .startPin);

/* File: plc_model.sv */
// Partner: controller and evaluation-core pins facing the link
`timescale 1ns/1ps
module plc_model #(
  parameter int ZERO_BAL_CYCLES = 5
) (
  input wire logic ref_clk,
  output logic startPin,
  output logic printPin,
  output logic evalDonePin,
  output logic [7:0] windowFailPin
);
  // Idle levels at time zero
  initial begin
    startPin = 1'b0;
    printPin = 1'b0;
    evalDonePin = 1'b0;
    windowFailPin = 8'h00;
  end
  // One press cycle; the zero balance wait is shortened, a real one lasts far longer
  task automatic measure(input logic [7:0] f);
    repeat (ZERO_BAL_CYCLES) @(posedge ref_clk);
    startPin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    windowFailPin <= f;
    repeat (3) @(posedge ref_clk);
    evalDonePin <= 1'b1;
    repeat (10) @(posedge ref_clk);
    evalDonePin <= 1'b0;
    windowFailPin <= ~f; // Stale lines must not leak into the held code
    startPin <= 1'b0;
    @(posedge ref_clk);
  endtask : measure
  // Print request is a pulse of three cycles, above the two-cycle minimum
  task automatic print_pulse();
    @(posedge ref_clk);
    printPin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    printPin <= 1'b0;
    @(posedge ref_clk);
  endtask : print_pulse
endmodule : plc_model

/* File: press_fit_plc_result_link_tb.sv */
// Testbench: register bus, verdict, wiring, check, print and recording
`timescale 1ns/1ps
module press_fit_plc_result_link_tb;
  logic ref_clk, rst_n, read, write, waitrequest, checkPin, wiringFaultPin, startPin, printPin;
  logic evalDonePin, passOut, fail_verdict_out, wiringOkOut_n, busyOut, checkFailOut;
  logic printStartOut, recordingOut, irqOut;
  logic [7:0] address, windowFailPin, f;
  logic [31:0] writedata, readdata, rd, seq;
  logic [3:0] byteenable, windowCodeOut;
  logic [11:0] forceValue, displValue;
  int n_fail = 0, compares = 0, np;
  press_fit_plc_result_link u_press_fit_plc_result_link (.ref_clk, .rst_n, .address, .read,
    .write, .writedata, .byteenable, .readdata, .waitrequest, .startPin, .checkPin, .printPin,
    .evalDonePin, .windowFailPin, .wiringFaultPin, .forceValue, .displValue, .passOut,
    .fail_verdict_out, .windowCodeOut, .wiringOkOut_n, .busyOut, .checkFailOut, .printStartOut,
    .recordingOut, .irqOut);
  plc_model u_plc_model (.ref_clk, .startPin, .printPin, .evalDonePin, .windowFailPin);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    if (n >= 50) chk(32'h0, 32'h1);
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  function automatic logic [3:0] exp_code(input logic [7:0] v);
    int n = 0;
    logic [3:0] c = 4'h0;
    for (int i = 0; i < 8; i++) if (v[i]) begin
      n++;
      c = 4'(i + 1);
    end
    return (n > 1) ? 4'hF : c;
  endfunction : exp_code
  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // Clock of 20 ns
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #(20 * 40000);
    n_fail++;
    tally_and_finish();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_n, read, write, checkPin, wiringFaultPin} = 5'h00;
    {address, writedata, byteenable} = '0;
    byteenable = 4'hF;
    forceValue = 12'h100;
    displValue = 12'h100;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk({31'h0, wiringOkOut_n}, 32'h1);
    bus(0, press_fit_pkg::CHECK_LIMIT_OFS, 32'h0);
    chk(rd, 32'h0000_0010);
    bus(0, 8'hFC, 32'h0);
    chk(rd, 32'h0);
    // Verdict and window code for each window, none, two and all
    for (int i = 0; i < 11; i++) begin
      f = i < 8 ? 8'(1 << i) : (i == 8 ? 8'h00 : (i == 9 ? 8'h05 : 8'hFF));
      u_plc_model.measure(f);
      repeat (4) @(posedge ref_clk);
      chk({30'h0, fail_verdict_out, passOut}, {30'h0, f != 0, f == 0});
      chk({28'h0, windowCodeOut}, {28'h0, exp_code(f)});
      chk({31'h0, busyOut}, 32'h0);
      bus(0, press_fit_pkg::RESULT_OFS, 32'h0);
      // Busy and check bits must read back low once the verdict stands
      chk(rd & 32'hFF, {26'h0, f != 0, f == 0, exp_code(f)});
    end
    // Without automatic recording a measurement alone opens no file
    chk({31'h0, recordingOut}, 32'h0);
    // Interrupt: masked, unmasked, cleared
    bus(1, press_fit_pkg::IRQ_MASK_OFS, 32'h0);
    bus(1, press_fit_pkg::IRQ_STATUS_OFS, 32'h3F);
    u_plc_model.measure(8'h02);
    bus(0, press_fit_pkg::IRQ_STATUS_OFS, 32'h0);
    chk(rd & 32'h2, 32'h2);
    chk({31'h0, irqOut}, 32'h0);
    bus(1, press_fit_pkg::IRQ_MASK_OFS, 32'h2);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, irqOut}, 32'h1);
    bus(1, press_fit_pkg::IRQ_STATUS_OFS, 32'h2);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, irqOut}, 32'h0);
    // Wiring fault and calibration both pull the active-low flag
    wiringFaultPin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk({31'h0, wiringOkOut_n}, 32'h0);
    wiringFaultPin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk({31'h0, wiringOkOut_n}, 32'h1);
    bus(1, press_fit_pkg::CTRL_OFS, 32'h8);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, wiringOkOut_n}, 32'h0);
    bus(1, press_fit_pkg::CTRL_OFS, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, wiringOkOut_n}, 32'h1);
    // Transducer check: inside, just outside tolerance, then request dropped
    bus(1, press_fit_pkg::CHECK_VALUE_OFS, 32'h0100_0100);
    checkPin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk({31'h0, checkFailOut}, 32'h0);
    forceValue <= 12'h111;
    repeat (8) @(posedge ref_clk);
    chk({31'h0, checkFailOut}, 32'h1);
    checkPin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk({31'h0, checkFailOut}, 32'h0);
    forceValue <= 12'h100;
    // Print pulse gives exactly one start pulse
    np = 0;
    fork
      u_plc_model.print_pulse();
      repeat (12) begin
        @(posedge ref_clk);
        if (printStartOut === 1'b1) np++;
      end
    join
    chk(32'(np), 32'h1);
    // Automatic and manual recording, stop bumps the counter
    bus(0, press_fit_pkg::SEQ_COUNT_OFS, 32'h0);
    seq = rd;
    bus(1, press_fit_pkg::CTRL_OFS, 32'h1);
    u_plc_model.measure(8'h00);
    chk({31'h0, recordingOut}, 32'h1);
    bus(1, press_fit_pkg::CTRL_OFS, 32'h4);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, recordingOut}, 32'h0);
    bus(0, press_fit_pkg::SEQ_COUNT_OFS, 32'h0);
    chk(rd, seq + 32'h1);
    bus(1, press_fit_pkg::CTRL_OFS, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, recordingOut}, 32'h1);
    bus(1, press_fit_pkg::FILE_NAME_LO_OFS, 32'h4443_4241);
    bus(1, press_fit_pkg::FILE_NAME_HI_OFS, 32'h4847_4645);
    bus(0, press_fit_pkg::FILE_NAME_LO_OFS, 32'h0);
    chk(rd, 32'h4443_4241);
    bus(0, press_fit_pkg::FILE_NAME_HI_OFS, 32'h0);
    chk(rd, 32'h4847_4645);
    // A single-lane write patches one character and keeps the rest
    byteenable <= 4'h1;
    bus(1, press_fit_pkg::FILE_NAME_LO_OFS, 32'h5A5A_5A5A);
    byteenable <= 4'hF;
    bus(0, press_fit_pkg::FILE_NAME_LO_OFS, 32'h0);
    chk(rd, 32'h4443_425A);
    tally_and_finish();
  end
endmodule : press_fit_plc_result_link_tb
